//--- rt_mailbox_dma_interface.v
// Subsystem side of a remote terminal: word and message checks, mailbox addressing,
// device-started DMA handshake, built-in-test word and an APB register slave.
// Assumes the decoder/encoder sit on pclk; pins from outside are synchronised here.
`include "rt_mailbox_dma_map.vh"
`default_nettype none
// Summary of operation
// - 14-bit address, 8 or 16-bit data
// - Check sync, encoding, parity, bit count
// - Legal defined command, matching word count
// - RT-to-RT: transmit bit set, timely status
// - 12 MHz mode selects dual-edge decoder sampling
// - Five address pins, parity, error, latch
// - Sample illegal-command input after fixed delay
// - Test word updated at message end
// - Real-time message and failure outputs
// - Pin selects two-state or three-state drive
// - Address fields: bcast, dir, sa, data, count, byte
// - One 64-word block per bcast/direction/subaddress
// - Command at 0 or mode code offset
// - Data at 32..63 or 32 plus mode
// - Last command, test word sent from registers
// - Device starts every transfer; read is inward
// - Request, grant, acknowledge, strobe, direction, fail
// - Byte mode: upper byte first, then lower
// - Grant timeout drives fail low, sets D12
// - Read failure on transmit aborts message
// - Write failure flags and continues message
module rt_mailbox_dma_interface #(
  parameter [19:0] ILL_DELAY_CYCLES = `ILL_SAMPLE_MS * `CLK_KHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_word_valid,
  input  wire [15:0] rx_word,
  input  wire        rx_command_sync,
  input  wire        rx_sync_ok,
  input  wire        rx_manchester_ok,
  input  wire        rx_parity_ok,
  input  wire        rx_bit_count_ok,
  input  wire        rx_bus_idle,
  input  wire        tx_word_ready,
  output reg         tx_word_valid,
  output reg  [15:0] tx_word,
  input  wire        looptest_fail,
  input  wire        transmitter_timeout,
  output reg         decoder_dual_edge,
  input  wire [4:0]  terminal_address_pins,
  input  wire        terminal_address_parity,
  input  wire        terminal_address_latch,
  output reg         address_parity_error_n,
  input  wire        command_illegal_n,
  input  wire        subsystem_busy_n,
  input  wire        three_state_select,
  output reg         transfer_request_n,
  input  wire        transfer_grant_n,
  output reg         transfer_acknowledge_n,
  output reg         transfer_strobe_n,
  output reg         write_direction,
  output reg         handshake_fail_n,
  output reg  [13:1] mailbox_address,
  output reg         byte_select,
  output reg         address_oe,
  output reg         control_oe,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg         data_oe,
  output reg         msg_start,
  output reg         msg_in_progress,
  output reg         msg_valid,
  output reg         msg_error,
  output reg         looptest_or_timeout
);
  localparam integer RT2RT_FULL = `RT2RT_TIMEOUT_NS / `CLK_PERIOD_NS;
  localparam [11:0] RT2RT_CYCLES = RT2RT_FULL[11:0];
  localparam [2:0] D_IDLE = 3'h0, D_REQ = 3'h1, D_ACK = 3'h2, D_STB = 3'h3, D_GAP = 3'h4;
  localparam [3:0] M_IDLE = 4'h0, M_CMDWR = 4'h1, M_RX = 4'h2, M_WSTAT = 4'h3, M_WILL = 4'h4,
                   M_STAT = 4'h5, M_TXRD = 4'h6, M_TXSEND = 4'h7, M_END = 4'h8;

  function is_mode;
    input [15:0] c;
    is_mode = (c[`CMD_SA_HI:`CMD_SA_LO] == `SA_MODE_LO) ||
              (c[`CMD_SA_HI:`CMD_SA_LO] == `SA_MODE_HI);
  endfunction

  // Mailbox address: broadcast, direction, subaddress, data/command, five-bit offset.
  function [13:1] box_addr;
    input [15:0] c;
    input        data_sel;
    input [4:0]  off;
    box_addr = {c[`CMD_RT_HI:`CMD_RT_LO] == `BCAST_ADDR, c[`CMD_TR],
                c[`CMD_SA_HI:`CMD_SA_LO], data_sel, off};
  endfunction

  function [5:0] expected_words;
    input [15:0] c;
    if (is_mode(c))
      expected_words = c[`MC_DATA_BIT] ? 6'h01 : 6'h00;
    else if (c[`CMD_WC_HI:`CMD_WC_LO] == 5'h00)
      expected_words = `WORDS_FULL;
    else
      expected_words = {1'b0, c[`CMD_WC_HI:`CMD_WC_LO]};
  endfunction

  // Mode codes outside the defined set, or with the wrong direction, are not legal.
  function mode_defined;
    input [15:0] c;
    reg [4:0] mc;
    begin
      mc = c[`CMD_WC_HI:`CMD_WC_LO];
      if (mc <= `MC_LAST_NO_DATA || mc == `MC_TX_VECTOR || mc == `MC_TX_LAST_CMD ||
          mc == `MC_TX_BIT_WORD)
        mode_defined = c[`CMD_TR];
      else if (mc == `MC_RX_SYNC || mc == `MC_RX_SEL_SHUT || mc == `MC_RX_SEL_OVR)
        mode_defined = !c[`CMD_TR];
      else
        mode_defined = 1'b0;
    end
  endfunction

  reg  [2:0]  ctrl_q;
  reg  [15:0] grant_timeout_q;
  reg  [15:0] bit_word_q, last_cmd_q, cmd_q, cmd2_q, pend_word_q, dma_wdata_q, dma_rdata_q;
  reg  [15:0] din_s1_q, din_s_q, dtimer_q;
  reg  [5:0]  addr_s1_q, addr_s_q;
  reg  [4:0]  rt_addr_q, pend_off_q;
  reg         rt_par_ok_q;
  reg  [3:0]  ctl_s1_q, ctl_s_q;
  reg  [2:0]  dst_q, stb_cnt_q;
  reg         second_q, dma_go_q, dma_wr_q, dma_done_q, dma_fail_q, dma_active_q;
  reg  [13:1] dma_addr_q;
  reg  [3:0]  mst_q;
  reg  [5:0]  wcnt_q;
  reg  [11:0] wait_q;
  reg  [19:0] ill_cnt_q;
  reg         ill_run_q, ill_done_q, ill_bad_q, pend_valid_q, idle_seen_q, rt2rt_q, fetch_q;
  reg         word_err_q, wc_err_q, hs_err_q, rt2rt_err_q, undef_q, tx_flt_q;

  wire grant_s    = ctl_s_q[0];
  wire illegal_s  = ctl_s_q[1];
  wire busy_n_s   = ctl_s_q[2];
  wire tri_s      = ctl_s_q[3];
  wire byte_mode  = ctrl_q[`CTRL_BYTE_MODE];
  wire word_ok    = rx_word_valid && rx_sync_ok && rx_manchester_ok && rx_parity_ok &&
                    rx_bit_count_ok;
  wire word_bad   = rx_word_valid && !word_ok;
  wire cmd_ok     = word_ok && rx_command_sync;
  wire data_ok    = word_ok && !rx_command_sync;
  wire own_or_bc  = (rx_word[`CMD_RT_HI:`CMD_RT_LO] == rt_addr_q && rt_par_ok_q) ||
                    rx_word[`CMD_RT_HI:`CMD_RT_LO] == `BCAST_ADDR;
  wire cmd_bcast  = cmd_q[`CMD_RT_HI:`CMD_RT_LO] == `BCAST_ADDR;
  wire [4:0] mc   = cmd_q[`CMD_WC_HI:`CMD_WC_LO];
  wire any_err    = word_err_q || wc_err_q || ill_bad_q || rt2rt_err_q || undef_q;
  wire [5:0] expw = expected_words(cmd_q);

  // Pins from the subsystem and the address straps cross into pclk through two flops.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_s1_q  <= 16'h0000;
      din_s_q   <= 16'h0000;
      addr_s1_q <= 6'h00;
      addr_s_q  <= 6'h00;
      ctl_s1_q  <= 4'hf;
      ctl_s_q   <= 4'hf;
    end else begin
      din_s1_q  <= data_in;
      din_s_q   <= din_s1_q;
      addr_s1_q <= {terminal_address_latch, terminal_address_parity ^ (^terminal_address_pins),
                    terminal_address_pins[3:0] ^ 4'h0};
      addr_s_q  <= addr_s1_q;
      ctl_s1_q  <= {three_state_select, subsystem_busy_n, command_illegal_n, transfer_grant_n};
      ctl_s_q   <= ctl_s1_q;
    end
  end

  // Terminal address behaves as a transparent latch, closed while the latch input is high.
  reg [4:0] rtp_s1_q, rtp_s_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtp_s1_q               <= 5'h00;
      rtp_s_q                <= 5'h00;
      rt_addr_q              <= 5'h00;
      rt_par_ok_q            <= 1'b0;
      address_parity_error_n <= 1'b1;
    end else begin
      rtp_s1_q <= terminal_address_pins;
      rtp_s_q  <= rtp_s1_q;
      if (!addr_s_q[5]) begin
        rt_addr_q   <= rtp_s_q;
        rt_par_ok_q <= addr_s_q[4];
      end
      address_parity_error_n <= addr_s_q[5] ? rt_par_ok_q : addr_s_q[4];
    end
  end

  // Handshake engine: request, wait for grant, acknowledge, one or two strobes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_q <= D_IDLE;
      dtimer_q <= 16'h0000;
      stb_cnt_q <= 3'h0;
      second_q <= 1'b0;
      dma_done_q <= 1'b0;
      dma_fail_q <= 1'b0;
      dma_rdata_q <= 16'h0000;
      transfer_request_n <= 1'b1;
      transfer_acknowledge_n <= 1'b1;
      transfer_strobe_n <= 1'b1;
      write_direction <= 1'b0;
      mailbox_address <= 13'h0000;
      byte_select <= 1'b0;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      address_oe <= 1'b0;
      control_oe <= 1'b0;
    end else begin
      dma_done_q <= 1'b0;
      dma_fail_q <= 1'b0;
      case (dst_q)
        D_IDLE: begin
          address_oe <= !tri_s;
          control_oe <= !tri_s;
          if (dma_go_q) begin
            transfer_request_n <= 1'b0;
            dtimer_q <= 16'h0000;
            dst_q <= D_REQ;
          end
        end
        D_REQ: begin
          if (!grant_s) begin
            transfer_acknowledge_n <= 1'b0;
            mailbox_address <= dma_addr_q;
            write_direction <= dma_wr_q;
            byte_select <= byte_mode;
            data_out <= byte_mode ? {8'h00, dma_wdata_q[15:8]} : dma_wdata_q;
            data_oe <= dma_wr_q;
            address_oe <= 1'b1;
            control_oe <= 1'b1;
            dst_q <= D_ACK;
          end else if (dtimer_q >= grant_timeout_q) begin
            transfer_request_n <= 1'b1;
            dma_fail_q <= 1'b1;
            dst_q <= D_IDLE;
          end else begin
            dtimer_q <= dtimer_q + 16'h0001;
          end
        end
        D_ACK, D_GAP: begin
          transfer_strobe_n <= 1'b0;
          stb_cnt_q <= 3'h0;
          dst_q <= D_STB;
        end
        D_STB: begin
          if (stb_cnt_q == `STROBE_CYCLES) begin
            transfer_strobe_n <= 1'b1;
            if (!byte_mode)
              dma_rdata_q <= din_s_q;
            else if (!second_q)
              dma_rdata_q[15:8] <= din_s_q[7:0];
            else
              dma_rdata_q[7:0] <= din_s_q[7:0];
            if (byte_mode && !second_q) begin
              second_q <= 1'b1;
              byte_select <= 1'b0;
              data_out <= {8'h00, dma_wdata_q[7:0]};
              dst_q <= D_GAP;
            end else begin
              second_q <= 1'b0;
              transfer_request_n <= 1'b1;
              transfer_acknowledge_n <= 1'b1;
              write_direction <= 1'b0;
              data_oe <= 1'b0;
              dma_done_q <= 1'b1;
              dst_q <= D_IDLE;
            end
          end else begin
            stb_cnt_q <= stb_cnt_q + 3'h1;
          end
        end
        default: dst_q <= D_IDLE;
      endcase
    end
  end

  // Message sequencer. A received word waits in a one-word holding slot for its write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_q <= M_IDLE;
      cmd_q <= 16'h0000;
      cmd2_q <= 16'h0000;
      last_cmd_q <= 16'h0000;
      bit_word_q <= 16'h0000;
      pend_word_q <= 16'h0000;
      pend_off_q <= 5'h00;
      pend_valid_q <= 1'b0;
      wcnt_q <= 6'h00;
      wait_q <= 12'h000;
      ill_cnt_q <= 20'h00000;
      {ill_run_q, ill_done_q, ill_bad_q, idle_seen_q, rt2rt_q, fetch_q} <= 6'h00;
      {word_err_q, wc_err_q, hs_err_q, rt2rt_err_q, undef_q, tx_flt_q} <= 6'h00;
      {dma_go_q, dma_wr_q, dma_active_q} <= 3'h0;
      dma_addr_q <= 13'h0000;
      dma_wdata_q <= 16'h0000;
      tx_word_valid <= 1'b0;
      tx_word <= 16'h0000;
      handshake_fail_n <= 1'b1;
      {msg_start, msg_in_progress, msg_valid, msg_error} <= 4'h0;
    end else begin
      dma_go_q <= 1'b0;
      msg_start <= 1'b0;
      msg_valid <= 1'b0;
      if (dma_done_q || dma_fail_q)
        dma_active_q <= 1'b0;
      if (dma_fail_q) begin
        handshake_fail_n <= 1'b0;
        hs_err_q <= 1'b1;
      end
      if (looptest_fail || transmitter_timeout)
        tx_flt_q <= 1'b1;
      if (ill_run_q) begin
        if (ill_cnt_q == ILL_DELAY_CYCLES - 20'h00001) begin
          ill_run_q <= 1'b0;
          ill_done_q <= 1'b1;
          ill_bad_q <= !illegal_s;
        end else begin
          ill_cnt_q <= ill_cnt_q + 20'h00001;
        end
      end
      case (mst_q)
        M_IDLE: begin
          if (cmd_ok && own_or_bc && ctrl_q[`CTRL_ENABLE]) begin
            cmd_q <= rx_word;
            if (!(is_mode(rx_word) && rx_word[`CMD_WC_HI:`CMD_WC_LO] == `MC_TX_LAST_CMD))
              last_cmd_q <= rx_word;
            undef_q <= is_mode(rx_word) && !mode_defined(rx_word);
            {word_err_q, wc_err_q, hs_err_q, rt2rt_err_q, tx_flt_q} <= 5'h00;
            {ill_done_q, ill_bad_q, idle_seen_q, rt2rt_q, fetch_q} <= 5'h00;
            ill_run_q <= 1'b1;
            ill_cnt_q <= 20'h00000;
            wcnt_q <= 6'h00;
            handshake_fail_n <= 1'b1;
            msg_start <= 1'b1;
            msg_in_progress <= 1'b1;
            msg_error <= 1'b0;
            dma_go_q <= 1'b1;
            dma_active_q <= 1'b1;
            dma_wr_q <= 1'b1;
            dma_wdata_q <= rx_word;
            dma_addr_q <= box_addr(rx_word, 1'b0, is_mode(rx_word) ?
                                   rx_word[`CMD_WC_HI:`CMD_WC_LO] : 5'h00);
            mst_q <= M_CMDWR;
          end
        end
        M_CMDWR: begin
          // A failed command write is only flagged; the message goes on.
          if (dma_done_q || dma_fail_q)
            mst_q <= cmd_q[`CMD_TR] ? M_WILL : M_RX;
        end
        M_RX: begin
          if (rx_bus_idle)
            idle_seen_q <= 1'b1;
          if (word_bad)
            word_err_q <= 1'b1;
          if (pend_valid_q && !dma_active_q) begin
            pend_valid_q <= 1'b0;
            dma_go_q <= 1'b1;
            dma_active_q <= 1'b1;
            dma_wr_q <= 1'b1;
            dma_wdata_q <= pend_word_q;
            dma_addr_q <= box_addr(cmd_q, 1'b1, pend_off_q);
          end
          if (data_ok) begin
            if (pend_valid_q && dma_active_q)
              word_err_q <= 1'b1;
            pend_valid_q <= 1'b1;
            pend_word_q <= rx_word;
            pend_off_q <= is_mode(cmd_q) ? mc : wcnt_q[4:0];
            wcnt_q <= wcnt_q + 6'h01;
          end else if (cmd_ok && wcnt_q == 6'h00 && !rt2rt_q && !cmd_bcast) begin
            if (rx_word[`CMD_TR]) begin
              cmd2_q <= rx_word;
              rt2rt_q <= 1'b1;
              wait_q <= 12'h000;
              mst_q <= M_WSTAT;
            end else begin
              rt2rt_err_q <= 1'b1;
            end
          end else if (idle_seen_q && !pend_valid_q && !dma_active_q) begin
            wc_err_q <= wcnt_q != expw;
            mst_q <= M_WILL;
          end
        end
        M_WSTAT: begin
          wait_q <= wait_q + 12'h001;
          if (cmd_ok) begin
            if (rx_word[`CMD_RT_HI:`CMD_RT_LO] == cmd2_q[`CMD_RT_HI:`CMD_RT_LO]) begin
              mst_q <= M_RX;
            end else begin
              rt2rt_err_q <= 1'b1;
              mst_q <= M_END;
            end
          end else if (wait_q == RT2RT_CYCLES) begin
            rt2rt_err_q <= 1'b1;
            mst_q <= M_END;
          end
        end
        M_WILL: begin
          if (ill_done_q) begin
            if (cmd_bcast) begin
              mst_q <= M_END;
            end else begin
              tx_word <= 16'h0000;
              tx_word[`CMD_RT_HI:`CMD_RT_LO] <= rt_addr_q;
              tx_word[`STAT_ME] <= any_err;
              tx_word[`STAT_BUSY] <= !busy_n_s;
              tx_word_valid <= 1'b1;
              mst_q <= M_STAT;
            end
          end
        end
        M_STAT: begin
          if (tx_word_ready) begin
            tx_word_valid <= 1'b0;
            wcnt_q <= 6'h00;
            if (cmd_q[`CMD_TR] && !any_err && busy_n_s && expw != 6'h00)
              mst_q <= M_TXRD;
            else
              mst_q <= M_END;
          end
        end
        M_TXRD: begin
          if (is_mode(cmd_q) && (mc == `MC_TX_LAST_CMD || mc == `MC_TX_BIT_WORD)) begin
            tx_word <= (mc == `MC_TX_LAST_CMD) ? last_cmd_q : bit_word_q;
            tx_word_valid <= 1'b1;
            mst_q <= M_TXSEND;
          end else if (!fetch_q) begin
            fetch_q <= 1'b1;
            dma_go_q <= 1'b1;
            dma_active_q <= 1'b1;
            dma_wr_q <= 1'b0;
            dma_addr_q <= box_addr(cmd_q, 1'b1, is_mode(cmd_q) ? mc : wcnt_q[4:0]);
          end else if (dma_fail_q) begin
            fetch_q <= 1'b0;
            mst_q <= M_END;
          end else if (dma_done_q) begin
            fetch_q <= 1'b0;
            tx_word <= dma_rdata_q;
            tx_word_valid <= 1'b1;
            mst_q <= M_TXSEND;
          end
        end
        M_TXSEND: begin
          if (tx_word_ready) begin
            tx_word_valid <= 1'b0;
            wcnt_q <= wcnt_q + 6'h01;
            mst_q <= (wcnt_q + 6'h01 == expw) ? M_END : M_TXRD;
          end
        end
        M_END: begin
          bit_word_q <= 16'h0000;
          bit_word_q[`BIT_HANDSHAKE_FAIL_N] <= hs_err_q;
          bit_word_q[`BIT_LOOPTEST] <= looptest_fail;
          bit_word_q[`BIT_TX_TIMEOUT] <= tx_flt_q;
          bit_word_q[`BIT_WC_ERR] <= wc_err_q;
          bit_word_q[`BIT_ILLEGAL] <= ill_bad_q || undef_q;
          bit_word_q[`BIT_WORD_ERR] <= word_err_q;
          bit_word_q[`BIT_RT2RT_ERR] <= rt2rt_err_q;
          msg_in_progress <= 1'b0;
          msg_valid <= !any_err && !hs_err_q;
          msg_error <= any_err || (hs_err_q && cmd_q[`CMD_TR]);
          ill_run_q <= 1'b0;
          pend_valid_q <= 1'b0;
          mst_q <= M_IDLE;
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end

  // APB slave: access phase lasts two cycles; read data is ready with pready.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      grant_timeout_q <= `GRANT_TIMEOUT_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      decoder_dual_edge <= 1'b0;
      looptest_or_timeout <= 1'b0;
    end else begin
      decoder_dual_edge <= ctrl_q[`CTRL_CLK12];
      looptest_or_timeout <= looptest_fail || transmitter_timeout;
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        case (paddr)
          `REG_CTRL:          prdata <= {29'h0, ctrl_q};
          `REG_GRANT_TIMEOUT: prdata <= {16'h0000, grant_timeout_q};
          `REG_STATUS:        prdata <= {26'h0, msg_in_progress, !handshake_fail_n, mst_q};
          `REG_BIT_WORD:      prdata <= {16'h0000, bit_word_q};
          `REG_LAST_CMD:      prdata <= {16'h0000, last_cmd_q};
          default:            pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite) begin
        if (paddr == `REG_CTRL)
          ctrl_q <= pwdata[2:0];
        if (paddr == `REG_GRANT_TIMEOUT)
          grant_timeout_q <= pwdata[15:0];
      end
    end
  end
endmodule // rt_mailbox_dma_interface
`default_nettype wire

//--- rt_mailbox_dma_map.vh
// Constants of the remote-terminal mailbox DMA block: register map, fields, timing.
// Assumes a 200 MHz pclk; included by the design file by its bare name.
`ifndef RT_MAILBOX_DMA_MAP_VH
`define RT_MAILBOX_DMA_MAP_VH
`define REG_CTRL            12'h000
`define REG_GRANT_TIMEOUT   12'h004
`define REG_STATUS          12'h008
`define REG_BIT_WORD        12'h00c
`define REG_LAST_CMD        12'h010
`define CTRL_ENABLE         0
`define CTRL_BYTE_MODE      1
`define CTRL_CLK12          2
`define CTRL_RESET          3'h0
`define GRANT_TIMEOUT_RESET 16'h0100
`define CMD_RT_HI           15
`define CMD_RT_LO           11
`define CMD_TR              10
`define CMD_SA_HI           9
`define CMD_SA_LO           5
`define CMD_WC_HI           4
`define CMD_WC_LO           0
`define BCAST_ADDR          5'h1f
`define SA_MODE_LO          5'h00
`define SA_MODE_HI          5'h1f
`define MC_DATA_BIT         4
`define MC_LAST_NO_DATA     5'h08
`define MC_TX_VECTOR        5'h10
`define MC_RX_SYNC          5'h11
`define MC_TX_LAST_CMD      5'h12
`define MC_TX_BIT_WORD      5'h13
`define MC_RX_SEL_SHUT      5'h14
`define MC_RX_SEL_OVR       5'h15
`define WORDS_FULL          6'h20
`define STAT_ME             10
`define STAT_BUSY           3
`define BIT_HANDSHAKE_FAIL_N         12
`define BIT_LOOPTEST        11
`define BIT_TX_TIMEOUT      10
`define BIT_WC_ERR          9
`define BIT_ILLEGAL         8
`define BIT_WORD_ERR        7
`define BIT_RT2RT_ERR       6
`define STROBE_CYCLES       3'h4
`define CLK_KHZ             200000
`define CLK_PERIOD_NS       5
`define ILL_SAMPLE_MS       5
`define RT2RT_TIMEOUT_NS    19500
`endif

//--- rt_mailbox_dma_interface_asserts.sv
// Checker of the DMA handshake and message outputs of the mailbox block.
// Assumes it sees only the block's ports; the strobe lasts five cycles.
`default_nettype none
module rt_mailbox_dma_interface_asserts (
  input wire logic        pclk, presetn, transfer_request_n, transfer_acknowledge_n,
  input wire logic        transfer_strobe_n, handshake_fail_n, write_direction,
  input wire logic        byte_select, data_oe, msg_start, msg_in_progress,
  input wire logic [13:1] mailbox_address
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ack_has_req: assert property (!transfer_acknowledge_n |-> !transfer_request_n)
    else $error("acknowledge without request");
  chk_strobe_in_ack: assert property (!transfer_strobe_n |-> !transfer_acknowledge_n)
    else $error("strobe outside acknowledge");
  chk_strobe_len: assert property ($fell(transfer_strobe_n) |->
    !transfer_strobe_n [*5] ##1 transfer_strobe_n) else $error("strobe length wrong");
  chk_addr_steady: assert property (!transfer_strobe_n && !$fell(transfer_strobe_n) |->
    $stable(mailbox_address) && $stable(byte_select)) else $error("address moved in strobe");
  chk_lower_second: assert property ($fell(byte_select) |->
    !transfer_acknowledge_n && transfer_strobe_n) else $error("byte order wrong");
  chk_fail_no_ack: assert property ($fell(handshake_fail_n) |-> transfer_acknowledge_n)
    else $error("failure during a transfer");
  chk_write_drives: assert property (data_oe |-> write_direction && !transfer_acknowledge_n)
    else $error("data driven outside a write");
  chk_start_flags: assert property ($rose(msg_start) |-> ##[0:2] msg_in_progress)
    else $error("start without in-progress");
endmodule // rt_mailbox_dma_interface_asserts
bind rt_mailbox_dma_interface rt_mailbox_dma_interface_asserts chk_u (.*);
`default_nettype wire

//--- rt_subsystem_model.sv
// Subsystem model: grants DMA requests after dly cycles and logs each write.
// Assumes the block's pclk; the bench sets dly.
`default_nettype none
module rt_subsystem_model (
  input  wire logic        pclk, transfer_request_n, transfer_acknowledge_n,
  input  wire logic        transfer_strobe_n, write_direction, byte_select,
  input  wire logic [13:1] mailbox_address,
  input  wire logic [15:0] data_out,
  input  wire logic [31:0] dly,
  output var  logic        transfer_grant_n,
  output var  logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [29:0] log_q [16];
  logic        s_q = 1, w_q = 0;
  int          cnt = 0, n = 0;
  initial transfer_grant_n = 1;
  initial data_in = 16'h0f0f;
  always @(posedge pclk) begin
    cnt <= transfer_request_n ? 0 : cnt + 1;
    transfer_grant_n <= transfer_request_n || cnt < dly;
    // An undriven bus flips each cycle so stale data never looks valid.
    data_in <= (!transfer_acknowledge_n && !write_direction) ? 16'ha5c3 : ~data_in;
    s_q <= transfer_strobe_n;
    if (!transfer_strobe_n) w_q <= write_direction;
    if (!transfer_strobe_n && write_direction) log_q[n] <= {byte_select, mailbox_address, data_out};
    if (!s_q && transfer_strobe_n && w_q) n <= n + 1;
  end
endmodule // rt_subsystem_model
`default_nettype wire

//--- test_rt_mailbox_dma_interface.sv
// Bench: APB register access and received messages into the subsystem model.
// Assumes rt_subsystem_model answers the DMA side.
`include "rt_mailbox_dma_map.vh"
`default_nettype none
module test_rt_mailbox_dma_interface;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, ok = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] rx_word = 0, tx_word, data_in, data_out, c1 = 16'h2862, c2 = 16'h2811, w;
  logic rx_word_valid = 0, rx_command_sync = 0, rx_bus_idle = 0, tx_word_ready = 1;
  logic looptest_fail = 0, transmitter_timeout = 0, terminal_address_latch = 0;
  logic command_illegal_n = 1, subsystem_busy_n = 1, three_state_select = 0;
  logic terminal_address_parity = 1, tx_word_valid, decoder_dual_edge, address_parity_error_n;
  logic [4:0] terminal_address_pins = 5'h05;
  logic transfer_request_n, transfer_grant_n, transfer_acknowledge_n, transfer_strobe_n;
  logic write_direction, handshake_fail_n, byte_select, address_oe, control_oe, data_oe;
  logic msg_start, msg_in_progress, msg_valid, msg_error, looptest_or_timeout;
  logic [13:1] mailbox_address;
  logic [29:0] l;
  wire rx_sync_ok = ok, rx_manchester_ok = ok, rx_parity_ok = ok, rx_bit_count_ok = ok;
  int miscompares = 0, samples_checked = 0, dly = 1;
  rt_mailbox_dma_interface #(.ILL_DELAY_CYCLES(20'd20)) dut_u (.*);
  rt_subsystem_model sub_u (.*);
  always #2.5 pclk = ~pclk;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic send(input logic cs, input logic [15:0] v);
    @(posedge pclk) {rx_word_valid, rx_command_sync, rx_word} <= {1'b1, cs, v};
    @(posedge pclk) rx_word_valid <= 0;
    repeat (40) @(posedge pclk);
  endtask
  task automatic finish_msg;
    @(posedge pclk) rx_bus_idle <= 1;
    @(posedge pclk) rx_bus_idle <= 0;
    do @(posedge pclk); while (tx_word_valid !== 1'b1);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `REG_GRANT_TIMEOUT, 0); check(rd, `GRANT_TIMEOUT_RESET);
    apb(0, 12'h020, 0); check({err, rd}, 33'h100000000);
    apb(1, `REG_CTRL, 1);
    send(1, c1); check(sub_u.log_q[0], {1'b0, 2'b00, 5'd3, 1'b0, 5'd0, c1});
    send(0, 16'h1234); check(sub_u.log_q[1], {3'b000, 5'd3, 1'b1, 5'd0, 16'h1234});
    send(0, 16'h5678); check(sub_u.log_q[2], {3'b000, 5'd3, 1'b1, 5'd1, 16'h5678});
    finish_msg; check(tx_word, 16'h2800);
    apb(1, `REG_CTRL, 3);
    send(1, c2);
    send(0, 16'hbeef);
    finish_msg;
    for (int k = 0; k < 4; k++) begin
      l = sub_u.log_q[3 + k];
      w = k < 2 ? c2 : 16'hbeef;
      check({l[29:16], l[7:0]}, {~k[0], 7'd0, k[1], 5'd17, k[0] ? w[7:0] : w[15:8]});
    end
    apb(1, `REG_CTRL, 1);
    // The encoder is held off so that the status and the fetched word each stand for a look.
    tx_word_ready <= 0;
    send(1, 16'h2c61); check(tx_word, 16'h2800);
    tx_word_ready <= 1;
    @(posedge pclk) tx_word_ready <= 0;
    repeat (30) @(posedge pclk);
    check({tx_word_valid, tx_word}, 17'h1a5c3);
    tx_word_ready <= 1;
    repeat (5) @(posedge pclk);
    apb(1, `REG_GRANT_TIMEOUT, 4);
    dly = 40;
    command_illegal_n <= 0;
    send(1, c1); check({handshake_fail_n, sub_u.n}, 33'd8);
    dly = 1;
    send(0, 16'h1111); check(sub_u.n, 9);
    finish_msg; check(tx_word[10], 1);
    repeat (5) @(posedge pclk);
    apb(0, `REG_BIT_WORD, 0); check(rd[`BIT_HANDSHAKE_FAIL_N], 1);
    command_illegal_n <= 1;
    ok <= 0;
    send(1, c1); check(sub_u.n, 9);
    ok <= 1;
    terminal_address_parity <= 0;
    repeat (4) @(posedge pclk);
    send(1, c1); check({address_parity_error_n, sub_u.n}, 33'd9);
    three_state_select <= 1;
    apb(1, `REG_CTRL, 4);
    repeat (2) @(posedge pclk);
    check({address_oe, decoder_dual_edge}, 2'b01);
    wrap_up;
  end
  initial begin
    #100us;
    miscompares++;
    wrap_up;
  end
endmodule // test_rt_mailbox_dma_interface
`default_nettype wire
